// ### inc/sgm_defs.svh
// register offsets, field positions, reset values and select codes for the signal modulator
// assumes inclusion by bare name from the package and the design module
`ifndef SGM_DEFS_SVH
`define SGM_DEFS_SVH

// register byte offsets on the apb bus
`define SGM_CTRL_OFS 12'h000
`define SGM_SRC_OFS 12'h004
`define SGM_CARRIER_HIGH_OFS 12'h008
`define SGM_CARRIER_LOW_OFS 12'h00c

// control register field positions
`define SGM_EN_BIT 7
`define SGM_OPOL_BIT 4
`define SGM_OUT_BIT 3
`define SGM_MBIT_BIT 0

// carrier register field positions
`define SGM_CPOL_BIT 6
`define SGM_CSYNC_BIT 5

// reset values
`define SGM_CTRL_RST 8'h00
`define SGM_SEL_RST 8'h00

// special select codes
`define SGM_SRC_MANUAL 4'h0
`define SGM_CAR_GND 4'h0
`define SGM_CAR_RSVD 4'h9

`endif

// ### inc/sgm_pkg.sv
// types shared by the signal modulator design
// assumes sgm_defs.svh is on the include path
package sgm_pkg;
    `include "sgm_defs.svh"

    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } sgm_apb_req_t;

    // one carrier control register
    typedef struct packed {
        logic invert;
        logic sync_en;
        logic [3:0] sel;
    } sgm_car_t;

    // all state of the modulator except the source synchronisers
    typedef struct packed {
        logic enable;
        logic out_inv;
        logic man_bit;
        logic [3:0] src_sel;
        sgm_car_t car_hi;
        sgm_car_t car_lo;
        logic sync_hi_on;
        logic sync_lo_on;
        logic hi_prev;
        logic lo_prev;
        logic [2:0] mod_sync;
        logic [1:0] hi_sync;
        logic [1:0] lo_sync;
        logic mod_out;
        logic pin_out;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } sgm_state_t;
endpackage : sgm_pkg

// ### hdl/sgm_modulator.sv
// signal modulator: mixes a data source with high or low carrier, apb registers
// assumes sources are free-running outputs from other logic or pins; resampled here
`timescale 1ns/1ps
`include "sgm_defs.svh"
module sgm_modulator
    import sgm_pkg::*;
(
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [15:0] DATA_SRC_IN,
    input wire logic [15:0] CARRIER_SRC_IN,
    output logic MOD_OUT_PIN
);

    ////////////////////////////////////////////////////////////////////////////
    sgm_state_t st_reg;
    sgm_state_t st_next;
    logic [15:0] data_s1_reg;
    logic [15:0] data_s2_reg;
    logic [15:0] car_s1_reg;
    logic [15:0] car_s2_reg;
    sgm_apb_req_t req;
    logic acc;
    logic hit;

    assign req = '{psel: PSEL, penable: PENABLE, pwrite: PWRITE, paddr: PADDR,
                   pwdata: PWDATA};

    ////////////////////////////////////////////////////////////////////////////
    // two-flop synchronisers per source bit; only stage two is read
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_sync
            always_ff @(posedge CLK) begin
                data_s1_reg[gi] <= DATA_SRC_IN[gi];
                data_s2_reg[gi] <= data_s1_reg[gi];
                car_s1_reg[gi] <= CARRIER_SRC_IN[gi];
                car_s2_reg[gi] <= car_s1_reg[gi];
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // carrier pick: code 0 is ground, reserved code reads zero
    function automatic logic pick_car(input logic [15:0] srcs, input sgm_car_t c,
                                      input logic en);
        logic v;
        v = 1'b0;
        if (en && c.sel != `SGM_CAR_GND && c.sel != `SGM_CAR_RSVD) begin
            v = srcs[c.sel];
        end
        return v ^ (c.invert & en);
    endfunction : pick_car

    ////////////////////////////////////////////////////////////////////////////
    // next state: register writes, sync tracking and output mixing
    always_comb begin
        logic data_v;
        logic hi_v;
        logic lo_v;
        logic hi_fall;
        logic lo_fall;
        logic mix;
        logic [31:0] rd;
        data_v = 1'b0;
        hi_v = 1'b0;
        lo_v = 1'b0;
        hi_fall = 1'b0;
        lo_fall = 1'b0;
        mix = 1'b0;
        rd = 32'h0000_0000;
        st_next = st_reg;
        acc = req.psel & req.penable;
        hit = (req.paddr == `SGM_CTRL_OFS) || (req.paddr == `SGM_SRC_OFS) ||
              (req.paddr == `SGM_CARRIER_HIGH_OFS) || (req.paddr == `SGM_CARRIER_LOW_OFS);

        // data source; manual bit forced while disabled
        if (!st_reg.enable || st_reg.src_sel == `SGM_SRC_MANUAL) begin
            data_v = st_reg.man_bit;
        end else begin
            data_v = data_s2_reg[st_reg.src_sel];
        end
        hi_v = pick_car(car_s2_reg, st_reg.car_hi, st_reg.enable);
        lo_v = pick_car(car_s2_reg, st_reg.car_lo, st_reg.enable);
        hi_fall = st_reg.hi_prev & ~hi_v;
        lo_fall = st_reg.lo_prev & ~lo_v;
        st_next.hi_prev = hi_v;
        st_next.lo_prev = lo_v;
        st_next.mod_sync = {st_reg.mod_sync[1:0], data_v};

        // high carrier gate; edge tracking only when sync enabled
        if (!st_reg.car_hi.sync_en) begin
            st_next.sync_hi_on = data_v;
        end else if (data_v) begin
            if (hi_fall) st_next.sync_hi_on = 1'b1;
        end else if (hi_fall) begin
            st_next.sync_hi_on = 1'b0;
        end
        // low carrier gate, mirror of the high side
        if (!st_reg.car_lo.sync_en) begin
            st_next.sync_lo_on = ~data_v;
        end else if (!data_v) begin
            if (lo_fall) st_next.sync_lo_on = 1'b1;
        end else if (lo_fall) begin
            st_next.sync_lo_on = 1'b0;
        end
        // unsynced carrier yields at once to a synced one still running
        if (data_v) begin
            mix = (st_reg.sync_hi_on | ~st_reg.car_hi.sync_en) & hi_v;
            if (st_reg.car_lo.sync_en && st_reg.sync_lo_on) mix = lo_v;
        end else begin
            mix = (st_reg.sync_lo_on | ~st_reg.car_lo.sync_en) & lo_v;
            if (st_reg.car_hi.sync_en && st_reg.sync_hi_on) mix = hi_v;
        end
        // data level already picked the carrier above, so only enable gates the result
        mix = mix & st_reg.enable;
        st_next.mod_out = mix;
        // disabled output holds the pin low whatever the polarity bit says
        st_next.pin_out = st_reg.enable ? (mix ^ st_reg.out_inv) : 1'b0;

        // apb: one registered answer, in the cycle after the access
        st_next.pready = 1'b0;
        st_next.pslverr = 1'b0;
        if (acc && !st_reg.pready) begin
            st_next.pready = 1'b1;
            st_next.pslverr = ~hit;
            case (req.paddr)
                `SGM_CTRL_OFS: begin
                    rd = {24'h000000, st_reg.enable, 2'b00, st_reg.out_inv,
                          st_reg.mod_out, 2'b00, st_reg.man_bit};
                end
                `SGM_SRC_OFS: begin
                    rd = {28'h0000000, st_reg.src_sel};
                end
                `SGM_CARRIER_HIGH_OFS: begin
                    rd = {25'h0000000, st_reg.car_hi.invert, st_reg.car_hi.sync_en, 1'b0,
                          st_reg.car_hi.sel};
                end
                `SGM_CARRIER_LOW_OFS: begin
                    rd = {25'h0000000, st_reg.car_lo.invert, st_reg.car_lo.sync_en, 1'b0,
                          st_reg.car_lo.sel};
                end
                default: begin
                    rd = 32'h0000_0000;
                end
            endcase
            st_next.prdata = rd;
            // writing enable leaves selections untouched
            if (req.pwrite) begin
                case (req.paddr)
                    `SGM_CTRL_OFS: begin
                        st_next.enable = req.pwdata[`SGM_EN_BIT];
                        st_next.out_inv = req.pwdata[`SGM_OPOL_BIT];
                        st_next.man_bit = req.pwdata[`SGM_MBIT_BIT];
                    end
                    `SGM_SRC_OFS: begin
                        st_next.src_sel = req.pwdata[3:0];
                    end
                    `SGM_CARRIER_HIGH_OFS: begin
                        st_next.car_hi = '{invert: req.pwdata[`SGM_CPOL_BIT],
                            sync_en: req.pwdata[`SGM_CSYNC_BIT], sel: req.pwdata[3:0]};
                    end
                    `SGM_CARRIER_LOW_OFS: begin
                        st_next.car_lo = '{invert: req.pwdata[`SGM_CPOL_BIT],
                            sync_en: req.pwdata[`SGM_CSYNC_BIT], sel: req.pwdata[3:0]};
                    end
                    default: begin
                        st_next.prdata = 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register; no sleep input, so it runs on in sleep
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from flops
    assign PRDATA = st_reg.prdata;
    assign PREADY = st_reg.pready;
    assign PSLVERR = st_reg.pslverr;
    assign MOD_OUT_PIN = st_reg.pin_out;

endmodule : sgm_modulator

// ### tb/sgm_modulator_sva.sv
// port checker for the signal modulator
// assumes bind onto sgm_modulator; apb answer one cycle after access
`timescale 1ns/1ps
module sgm_modulator_sva
    import sgm_pkg::*;
(
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic [15:0] DATA_SRC_IN,
    input wire logic [15:0] CARRIER_SRC_IN,
    input wire logic MOD_OUT_PIN
);
    // one domain, so clock and reset are given once
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RSTN);
    AST_READY_NEXT: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
        else $error("access not answered next cycle");
    AST_READY_PULSE: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    AST_READY_CAUSE: assert property (PREADY |-> $past(PSEL) && $past(PENABLE))
        else $error("ready without access");
    AST_UNMAPPED: assert property (PREADY && PADDR > 12'h00c |-> PSLVERR && PRDATA == 32'h0)
        else $error("unmapped access not refused");
    AST_UPPER_ZERO: assert property (PREADY && !PWRITE |-> PRDATA[31:8] == 24'h0)
        else $error("read data upper bits set");
    AST_RESET_QUIET: assert property ($rose(RSTN) |-> !MOD_OUT_PIN && !PREADY)
        else $error("outputs active after reset");
    AST_DISABLED_LOW: assert property (PREADY && PWRITE && PADDR == 12'h000
        && PWDATA[7:0] == 8'h00 |-> ##[1:6] !MOD_OUT_PIN)
        else $error("disabled pin not low");
    AST_DISABLED_INV: assert property (PREADY && PWRITE && PADDR == 12'h000
        && PWDATA[7:0] == 8'h10 |-> ##[1:6] !MOD_OUT_PIN)
        else $error("disabled pin not low with output inverted");
endmodule : sgm_modulator_sva
////////////////////////////////////////////////////////////////
bind sgm_modulator sgm_modulator_sva u_sva (
    .CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .DATA_SRC_IN(DATA_SRC_IN), .CARRIER_SRC_IN(CARRIER_SRC_IN), .MOD_OUT_PIN(MOD_OUT_PIN)
);

// ### tb/sgm_src_model.sv
// peripheral outputs and pins feeding the modulator sources
// assumes bench sets the levels; the ground line is held low and the reserved line is driven here
`timescale 1ns/1ps
module sgm_src_model (
    input wire logic clk,
    input wire logic [15:0] data_lvl,
    input wire logic [15:0] car_lvl,
    output logic [15:0] data_src,
    output logic [15:0] car_src
);
    logic rsvd_reg = 1'b0;
    // reserved line toggles so a wrong hookup shows up at the pin
    always @(posedge clk) begin
        rsvd_reg <= !rsvd_reg;
        data_src <= data_lvl;
        car_src <= {car_lvl[15:10], rsvd_reg, car_lvl[8:1], 1'b0};
    end
endmodule : sgm_src_model

// ### tb/sgm_modulator_tb.sv
// self-checking bench for the signal modulator
// assumes pin settles within 8 cycles of a source or register change
`timescale 1ns/1ps
`include "sgm_defs.svh"
module sgm_modulator_tb
    import sgm_pkg::*;
;
    logic clk = 1'b0;
    logic rstn;
    sgm_apb_req_t req;
    logic [31:0] prdata;
    logic pready;
    logic [15:0] dsrc, csrc, dl, cl;
    logic pin;
    logic pslverr;
    logic err;
    int failures = 0;
    int check_count = 0;
    always #4 clk = ~clk;
    sgm_modulator dut (
        .CLK(clk), .RSTN(rstn), .PSEL(req.psel), .PENABLE(req.penable), .PWRITE(req.pwrite),
        .PADDR(req.paddr), .PWDATA(req.pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .DATA_SRC_IN(dsrc), .CARRIER_SRC_IN(csrc), .MOD_OUT_PIN(pin)
    );
    sgm_src_model src (.clk(clk), .data_lvl(dl), .car_lvl(cl), .data_src(dsrc), .car_src(csrc));
    ////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    // request held until ready is seen high at an edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) failures++;
        r = prdata;
        err = pslverr;
        req <= '0;
        @(posedge clk);
    endtask : apb
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask : wr
    task rd(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        chk(r, e);
    endtask : rd
    // set source levels, let the sync stages flush, then look at the pin
    task src_pin(input logic [15:0] d, input logic [15:0] c, input logic e);
        dl <= d;
        cl <= c;
        repeat (8) @(posedge clk);
        chk({31'h0, pin}, {31'h0, e});
    endtask : src_pin
    task give_verdict;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////////
    initial begin
        rstn = 1'b0;
        req = '0;
        dl = 16'h0;
        cl = 16'h0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 5; i++) rd(12'(i * 4), 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("test reset done");
        wr(`SGM_SRC_OFS, 32'h1);
        wr(`SGM_CARRIER_HIGH_OFS, 32'h1);
        wr(`SGM_CARRIER_LOW_OFS, 32'h2);
        wr(`SGM_CTRL_OFS, 32'h80);
        src_pin(16'h0002, 16'h0002, 1'b1);
        wr(`SGM_SRC_OFS, 32'h5);
        src_pin(16'h0020, 16'h0002, 1'b1);
        wr(`SGM_SRC_OFS, 32'h1);
        src_pin(16'h0002, 16'h0000, 1'b0);
        src_pin(16'h0000, 16'h0006, 1'b1);
        wr(`SGM_CARRIER_LOW_OFS, 32'h42);
        src_pin(16'h0000, 16'h0002, 1'b1);
        wr(`SGM_CARRIER_LOW_OFS, 32'h2);
        wr(`SGM_CARRIER_HIGH_OFS, 32'h41);
        src_pin(16'h0002, 16'h0004, 1'b1);
        wr(`SGM_CTRL_OFS, 32'h90);
        src_pin(16'h0002, 16'h0004, 1'b0);
        $display("test mixing done");
        wr(`SGM_CTRL_OFS, 32'h00);
        src_pin(16'h0002, 16'h0004, 1'b0);
        wr(`SGM_CTRL_OFS, 32'h10);
        src_pin(16'h0002, 16'h0004, 1'b0);
        rd(`SGM_SRC_OFS, 32'h1);
        rd(`SGM_CARRIER_HIGH_OFS, 32'h41);
        rd(`SGM_CARRIER_LOW_OFS, 32'h2);
        wr(`SGM_CTRL_OFS, 32'h80);
        src_pin(16'h0002, 16'h0004, 1'b1);
        $display("test enable done");
        wr(`SGM_SRC_OFS, 32'h0);
        wr(`SGM_CARRIER_HIGH_OFS, 32'h1);
        wr(`SGM_CTRL_OFS, 32'h81);
        src_pin(16'h0000, 16'h0002, 1'b1);
        rd(`SGM_CTRL_OFS, 32'h89);
        wr(`SGM_CTRL_OFS, 32'h80);
        src_pin(16'h0000, 16'h0002, 1'b0);
        wr(`SGM_CARRIER_HIGH_OFS, 32'h9);
        wr(`SGM_CTRL_OFS, 32'h81);
        src_pin(16'h0000, 16'h0202, 1'b0);
        $display("test manual done");
        // high carrier synced: it must finish its pulse, and wait for a fall to start
        wr(`SGM_CARRIER_HIGH_OFS, 32'h21);
        wr(`SGM_SRC_OFS, 32'h1);
        wr(`SGM_CTRL_OFS, 32'h80);
        src_pin(16'h0000, 16'h0002, 1'b1);
        src_pin(16'h0000, 16'h0004, 1'b1);
        src_pin(16'h0002, 16'h0006, 1'b0);
        src_pin(16'h0002, 16'h0004, 1'b0);
        src_pin(16'h0002, 16'h0006, 1'b1);
        // low carrier synced on its own, high left free
        wr(`SGM_CARRIER_HIGH_OFS, 32'h1);
        wr(`SGM_CARRIER_LOW_OFS, 32'h22);
        src_pin(16'h0000, 16'h0006, 1'b0);
        src_pin(16'h0000, 16'h0002, 1'b0);
        src_pin(16'h0000, 16'h0006, 1'b1);
        $display("test sync done");
        // reset in mid-run must clear the pin and the registers again
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk({31'h0, pin}, 32'h0);
        rd(`SGM_CARRIER_LOW_OFS, 32'h0);
        rd(`SGM_CTRL_OFS, 32'h0);
        $display("test second reset done");
        give_verdict;
    end
    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        give_verdict;
    end
endmodule : sgm_modulator_tb
